// file: bench/process_mem_model.sv
// process memory stand-in answering word fetches after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module process_mem_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic [1:0] delay,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic busy;
	logic [1:0] left;
	logic [15:0] addr;
	// data toggles outside the ack cycle so a stale word never passes for fresh
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (sys_rst) begin
			busy <= 1'b0;
			mem_rdata <= 32'h0;
		end else if (busy && left == 2'h0) begin
			busy <= 1'b0;
			mem_ack <= 1'b1;
			mem_rdata <= {addr[7:0] + 8'h03, addr[7:0] + 8'h02, addr[7:0] + 8'h01, addr[7:0]};
		end else if (busy) begin
			left <= left - 2'h1;
		end else if (mem_req) begin
			busy <= 1'b1;
			left <= delay;
			addr <= mem_addr;
		end
	end
endmodule : process_mem_model
`default_nettype wire

// file: bench/process_memory_read_mover_sva.sv
// port assertions for the process memory read mover
`timescale 1ns/1ps
`default_nettype none
module process_ram_read_mover_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic cmd_rd;
	logic cancel_wr;
	assign cmd_rd = reg_rd && reg_addr == process_ram_read_pkg::CMD_OFFSET;
	assign cancel_wr = reg_wr && reg_addr == process_ram_read_pkg::CMD_OFFSET && reg_be[3]
		&& reg_wdata[process_ram_read_pkg::CANCEL_BIT];
	AST_RESET: assert property (disable iff (1'b0) sys_rst |=> reg_rdata == 32'h0 && !mem_req)
		else $error("reset");
	AST_RESERVED: assert property (cmd_rd |=> reg_rdata[29:13] == 17'h0 && reg_rdata[7:1] == 7'h0)
		else $error("reserved");
	AST_CNT_MAX: assert property (cmd_rd |=> reg_rdata[12:8] <= process_ram_read_pkg::CNT_FULL)
		else $error("count");
	AST_AVAIL: assert property (cmd_rd |=> reg_rdata[0] == (reg_rdata[12:8] != 5'h00))
		else $error("avail");
	AST_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
		else $error("align");
	AST_CANCEL: assert property (cancel_wr |=> !mem_req)
		else $error("cancel");
	AST_QUIET: assert property ($past(sys_rst) && !reg_wr |=> !mem_req)
		else $error("quiet");
	AST_BUSY_READ: assert property (cmd_rd && mem_req |=> reg_rdata[31])
		else $error("busy");
endmodule : process_ram_read_mover_sva
bind process_ram_read_mover process_ram_read_mover_sva i_sva (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_be,
	.reg_wdata, .reg_rdata, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
`default_nettype wire

// file: bench/process_ram_read_mover_tb.sv
// self-checking bench for the process memory read mover
`timescale 1ns/1ps
`default_nettype none
module process_ram_read_mover_tb;
	localparam logic [11:0] LEN_REG = process_ram_read_pkg::ADDR_LEN_OFFSET;
	localparam logic [11:0] CMD_REG = process_ram_read_pkg::CMD_OFFSET;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] reg_be = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata, mem_rdata, d;
	logic [31:0] seed = 32'hc065;
	logic mem_req, mem_ack;
	logic [15:0] mem_addr;
	logic [1:0] delay = 2'h0;
	int failures = 0;
	int total_checks = 0;
	always #10 clk = ~clk;
	process_ram_read_mover i_process_ram_read_mover (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_be, .reg_wdata,
		.reg_rdata, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
	process_mem_model i_process_mem_model (.clk, .sys_rst, .mem_req, .mem_addr, .delay, .mem_ack, .mem_rdata);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] status(input logic busy, input int cnt);
		return {busy, 18'h0, cnt[4:0], 7'h0, cnt != 0};
	endfunction : status
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] v);
		@(posedge clk);
		{reg_wr, reg_addr, reg_be, reg_wdata} <= {1'b1, a, be, v};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [3:0] be);
		@(posedge clk);
		{reg_rd, reg_addr, reg_be} <= {1'b1, a, be};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic xfer(input logic [15:0] a, input logic [15:0] n);
		int words;
		logic [15:0] w;
		words = (a[1:0] + n + 3) / 4;
		seed = lfsr(seed);
		delay <= seed[1:0];
		wr(LEN_REG, 4'hf, {n, a});
		wr(CMD_REG, 4'h8, 32'h8000_0000);
		d = 32'hffff_ffff;
		for (int i = 0; i < 100 && d[31] !== 1'b0; i++) rd(CMD_REG, 4'hf);
		check("status", d, status(1'b0, words));
		rd(LEN_REG, 4'hf);
		check("fields", d, {16'h0, a + n});
		rd(12'h000, 4'h3);
		rd(CMD_REG, 4'hf);
		check("partial", d, status(1'b0, words));
		for (int k = 0; k < words; k++) begin
			w = {a[15:2], 2'b00} + 16'(4 * k);
			rd({7'h0, k[2:0], 2'b00}, k == 0 ? 4'hc : 4'hf);
			check("fifo", d, {w[7:0] + 8'h03, w[7:0] + 8'h02, w[7:0] + 8'h01, w[7:0]});
		end
		rd(CMD_REG, 4'hf);
		check("drained", d, 32'h0);
	endtask : xfer
	task automatic results;
		if (failures == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(LEN_REG, 4'hf);
		check("len reset", d, 32'h0);
		wr(LEN_REG, 4'h5, 32'h1234_5678);
		rd(LEN_REG, 4'hf);
		check("lane write", d, 32'h0034_0078);
		wr(CMD_REG, 4'hf, 32'h3fff_ffff);
		rd(CMD_REG, 4'hf);
		check("reserved", d, 32'h0);
		xfer(16'h2ffd, 16'h0003);
		xfer(16'h1001, 16'h0006);
		repeat (12) begin
			seed = lfsr(seed);
			xfer(16'h1000 + {4'h0, seed[11:0]}, {11'h0, seed[16:12]} + 16'h0001);
		end
		// twenty words: fetch must park at sixteen
		wr(LEN_REG, 4'hf, 32'h0050_1000);
		wr(CMD_REG, 4'h8, 32'h8000_0000);
		for (int i = 0; i < 100 && d[12:8] !== 5'h10; i++) rd(CMD_REG, 4'hf);
		check("full", d, status(1'b1, 16));
		wr(CMD_REG, 4'hf, 32'h0);
		rd(CMD_REG, 4'hf);
		check("zero write", d, status(1'b1, 16));
		wr(CMD_REG, 4'h8, 32'hc000_0000);
		rd(CMD_REG, 4'hf);
		check("cancel", d, 32'h0);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(LEN_REG, 4'hf);
		check("len rereset", d, 32'h0);
		results();
	end
endmodule : process_ram_read_mover_tb
`default_nettype wire

// file: design/process_memory_read_fifo.sv
// dword fifo between the fetch engine and the host data port
`timescale 1ns/1ps
`default_nettype none
module process_ram_read_fifo (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic push,
	input wire logic [31:0] push_data,
	input wire logic pop,
	output logic [31:0] head_data,
	output logic [4:0] count
);
	logic [31:0] mem [process_ram_read_pkg::FIFO_DEPTH];
	logic [3:0] rd_ptr;
	logic [3:0] wr_ptr;
	logic [3:0] next_rd_ptr;
	logic [3:0] next_wr_ptr;
	logic [4:0] next_count;
	logic do_push;
	logic do_pop;

	always_comb begin
		do_push = push && (count != process_ram_read_pkg::CNT_FULL);
		do_pop = pop && (count != process_ram_read_pkg::CNT_RESET);
		next_rd_ptr = rd_ptr + 4'(do_pop);
		next_wr_ptr = wr_ptr + 4'(do_push);
		next_count = count + 5'(do_push) - 5'(do_pop);
		if (flush) begin
			next_rd_ptr = '0;
			next_wr_ptr = '0;
			next_count = process_ram_read_pkg::CNT_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= process_ram_read_pkg::CNT_RESET;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge clk) begin
		if (do_push && !flush) begin
			mem[wr_ptr] <= push_data;
		end
	end

	assign head_data = mem[rd_ptr];
endmodule : process_ram_read_fifo
`default_nettype wire

// file: design/process_memory_read_mover.sv
// process memory read mover: address/length, command/status and read fifo
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - length field counts down as bytes fetched
// - address field counts up as bytes fetched
// - writing busy one starts fetch
// - busy self-clears when transfer completes
// - writing zero to busy or cancel: nothing
// - cancel stops, clears busy, flushes fifo
// - five-bit count of readable dwords
// - count drops only on complete dword read or cancel
// - bit zero shows fifo holds data
// - both address/length fields rw while idle, reset zero
// - 32-bit read-only fifo data port
module process_ram_read_mover (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic mem_req,
	output logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [15:0] read_byte_count;
	logic [15:0] read_start_byte_addr;
	logic read_in_progress;
	logic [15:0] next_read_byte_count;
	logic [15:0] next_read_start_byte_addr;
	logic next_read_in_progress;
	process_ram_read_pkg::eng_state_t state;
	process_ram_read_pkg::eng_state_t next_state;
	logic [31:0] next_reg_rdata;

	// ----------------------------------------------------------------
	// decoded host strokes
	// ----------------------------------------------------------------
	logic wr_len;
	logic wr_cmd;
	logic cmd_top_lane;
	logic read_cancel;
	logic read_start;
	logic [1:0] len_be;
	logic [1:0] addr_be;
	logic [15:0] wdata_len;
	logic [15:0] wdata_addr;

	// ----------------------------------------------------------------
	// fifo and fetch handshake
	// ----------------------------------------------------------------
	logic [3:0] lane_seen;
	logic [3:0] next_lane_seen;
	logic fifo_hit;
	logic pop;
	logic push;
	logic [4:0] fifo_dword_count;
	logic [31:0] fifo_head;
	logic fifo_has_data;
	logic fifo_room;
	logic [15:0] step;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// smaller of two byte counts
	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction : min16

	// half-word write lane by lane; unselected bytes keep their value
	function automatic logic [15:0] merge_half(input logic [15:0] old, input logic [1:0] be, input logic [15:0] data);
		merge_half = old;
		if (be[1]) begin
			merge_half[15:8] = data[15:8];
		end
		if (be[0]) begin
			merge_half[7:0] = data[7:0];
		end
	endfunction : merge_half

	// ----------------------------------------------------------------
	// host stroke decode
	// ----------------------------------------------------------------
	always_comb begin
		wr_len = reg_wr && (reg_addr == process_ram_read_pkg::ADDR_LEN_OFFSET);
		wr_cmd = reg_wr && (reg_addr == process_ram_read_pkg::CMD_OFFSET);
		// both command bits share the top byte lane
		cmd_top_lane = wr_cmd && reg_be[process_ram_read_pkg::BUSY_BIT / 8];
		len_be = reg_be[process_ram_read_pkg::LEN_MSB / 8 -: 2];
		addr_be = reg_be[process_ram_read_pkg::ADDR_MSB / 8 -: 2];
		wdata_len = reg_wdata[process_ram_read_pkg::LEN_MSB:process_ram_read_pkg::LEN_LSB];
		wdata_addr = reg_wdata[process_ram_read_pkg::ADDR_MSB:process_ram_read_pkg::ADDR_LSB];
		// a zero in either command bit is no stroke at all
		read_cancel = cmd_top_lane && reg_wdata[process_ram_read_pkg::CANCEL_BIT];
		read_start = cmd_top_lane && reg_wdata[process_ram_read_pkg::BUSY_BIT] && !read_cancel;
	end

	// ----------------------------------------------------------------
	// fetch handshake
	// ----------------------------------------------------------------
	always_comb begin
		// the data window starts at offset zero, so only its top bound is tested
		fifo_hit = (reg_addr <= process_ram_read_pkg::FIFO_OFFSET_HI);
		fifo_has_data = (fifo_dword_count != process_ram_read_pkg::CNT_RESET);
		fifo_room = (fifo_dword_count < process_ram_read_pkg::CNT_FULL);
		// bytes of the current dword before the next word boundary, capped by the bytes left
		step = min16(process_ram_read_pkg::DWORD_BYTES - {14'h0000, read_start_byte_addr[1:0]}, read_byte_count);
		push = (state == process_ram_read_pkg::ENG_WAIT) && mem_ack;
		// ask only while bytes remain and the fifo has room, so memory never
		// answers a request that the engine would have to throw away
		mem_req = (state == process_ram_read_pkg::ENG_REQ) && fifo_room
			&& (read_byte_count != process_ram_read_pkg::FIELD_RESET);
		mem_addr = {read_start_byte_addr[15:2], 2'b00};
	end

	// ----------------------------------------------------------------
	// host data port
	// ----------------------------------------------------------------
	// a dword leaves the fifo once all four lanes were read, in any order
	always_comb begin
		next_lane_seen = lane_seen;
		pop = 1'b0;
		if (reg_rd && fifo_hit) begin
			next_lane_seen = lane_seen | reg_be;
			if (next_lane_seen == process_ram_read_pkg::ALL_LANES) begin
				pop = 1'b1;
				next_lane_seen = '0;
			end
		end
		// cancel also forgets a half-read word
		if (read_cancel) begin
			next_lane_seen = '0;
		end
	end

	// ----------------------------------------------------------------
	// fetch engine
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_read_byte_count = read_byte_count;
		next_read_start_byte_addr = read_start_byte_addr;
		next_read_in_progress = read_in_progress;
		// host writes leave the fields alone while a fetch runs; only the engine moves them
		if (wr_len && !read_in_progress) begin
			next_read_byte_count = merge_half(read_byte_count, len_be, wdata_len);
			next_read_start_byte_addr = merge_half(read_start_byte_addr, addr_be, wdata_addr);
		end
		case (state)
			process_ram_read_pkg::ENG_IDLE: begin
				if (read_start) begin
					next_read_in_progress = 1'b1;
					next_state = process_ram_read_pkg::ENG_REQ;
				end
			end
			process_ram_read_pkg::ENG_REQ: begin
				if (read_byte_count == process_ram_read_pkg::FIELD_RESET) begin
					next_read_in_progress = 1'b0;
					next_state = process_ram_read_pkg::ENG_IDLE;
				end else if (fifo_room) begin
					// a full fifo parks the engine here until the host reads
					next_state = process_ram_read_pkg::ENG_WAIT;
				end
			end
			process_ram_read_pkg::ENG_WAIT: begin
				if (mem_ack) begin
					next_read_byte_count = read_byte_count - step;
					next_read_start_byte_addr = read_start_byte_addr + step;
					next_state = process_ram_read_pkg::ENG_REQ;
				end
			end
			default: next_state = process_ram_read_pkg::ENG_IDLE;
		endcase
		// cancel wins over a start written in the same stroke
		if (read_cancel) begin
			next_read_in_progress = 1'b0;
			next_state = process_ram_read_pkg::ENG_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		next_reg_rdata = '0;
		if (reg_addr == process_ram_read_pkg::ADDR_LEN_OFFSET) begin
			next_reg_rdata = {read_byte_count, read_start_byte_addr};
		end else if (reg_addr == process_ram_read_pkg::CMD_OFFSET) begin
			// cancel self-clears at once, so its bit always reads zero
			next_reg_rdata[process_ram_read_pkg::BUSY_BIT] = read_in_progress;
			next_reg_rdata[process_ram_read_pkg::CNT_MSB:process_ram_read_pkg::CNT_LSB] = fifo_dword_count;
			next_reg_rdata[process_ram_read_pkg::AVAIL_BIT] = fifo_has_data;
		end else if (fifo_hit) begin
			next_reg_rdata = fifo_head;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= process_ram_read_pkg::ENG_IDLE;
			read_byte_count <= process_ram_read_pkg::FIELD_RESET;
			read_start_byte_addr <= process_ram_read_pkg::FIELD_RESET;
			read_in_progress <= 1'b0;
			lane_seen <= '0;
			reg_rdata <= '0;
		end else begin
			state <= next_state;
			read_byte_count <= next_read_byte_count;
			read_start_byte_addr <= next_read_start_byte_addr;
			read_in_progress <= next_read_in_progress;
			lane_seen <= next_lane_seen;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// read fifo; cancel flushes it along with its status
	// ----------------------------------------------------------------
	process_ram_read_fifo i_process_ram_read_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.flush(read_cancel),
		.push(push),
		.push_data(mem_rdata),
		.pop(pop),
		.head_data(fifo_head),
		.count(fifo_dword_count)
	);
endmodule : process_ram_read_mover
`default_nettype wire

// file: design/process_memory_read_pkg.sv
// constants shared by the process memory read mover
package process_ram_read_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_LEN_OFFSET = 12'h308;
	localparam logic [11:0] CMD_OFFSET = 12'h30c;
	localparam logic [11:0] FIFO_OFFSET_LO = 12'h000;
	localparam logic [11:0] FIFO_OFFSET_HI = 12'h01c;
	localparam int LEN_MSB = 31;
	localparam int LEN_LSB = 16;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 0;
	localparam int BUSY_BIT = 31;
	localparam int CANCEL_BIT = 30;
	localparam int CNT_MSB = 12;
	localparam int CNT_LSB = 8;
	localparam int AVAIL_BIT = 0;
	localparam logic [15:0] FIELD_RESET = 16'h0000;
	// ----------------------------------------------------------------
	// fifo geometry
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam logic [4:0] CNT_RESET = 5'h00;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [15:0] DWORD_BYTES = 16'h0004;
	localparam logic [3:0] ALL_LANES = 4'hf;
	typedef enum logic [1:0] {ENG_IDLE, ENG_REQ, ENG_WAIT} eng_state_t;
endpackage : process_ram_read_pkg
